/* core/alm_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module alm_regs (
   input  wire logic              core_clk_i,
   input  wire logic              rst_i,
   input  wire logic              ce_i,
   input  wire alm_pkg::alm_ptr_t ptr_i,
   input  wire logic              wr_i,
   input  wire alm_pkg::alm_word_t wdata_i,
   output alm_pkg::alm_word_t     rdata_o,
   output logic                   rhit_o,
   input  wire logic              conv_valid_i,
   input  wire alm_pkg::alm_code_t conv_code_i,
   input  wire logic [2:0]        cycle_time_i,
   input  wire logic              alert_hold_i,
   input  wire logic              clr_over_i,
   input  wire logic              clr_under_i,
   output logic                   over_flag_o,
   output logic                   under_flag_o
);
   import alm_pkg::*;

   alm_code_t under_r, over_r, hyst_r, lowest_r, high_r;
   logic      lowest_fresh_r, high_fresh_r;
   alm_word_t rdata_r;
   logic      rhit_r;

   wire       auto_mode;
   wire       track;
   wire       wr_under, wr_over, wr_hyst, wr_lowest, wr_high;
   wire alm_code_t wfield;
   wire       below_under, above_over;
   wire [8:0] under_plus, over_minus;
   wire       under_rel, over_rel;
   wire       lower_seen, higher_seen;
   wire       lowest_restart, high_restart;
   alm_word_t rd_sel;

   assign auto_mode = (cycle_time_i != ALM_CYC_OFF);
   assign track     = ce_i && conv_valid_i && auto_mode;

   assign wr_under  = wr_i && (ptr_i == ALM_PTR_UNDER);
   assign wr_over   = wr_i && (ptr_i == ALM_PTR_OVER);
   assign wr_hyst   = wr_i && (ptr_i == ALM_PTR_HYST);
   assign wr_lowest = wr_i && (ptr_i == ALM_PTR_LOWEST);
   assign wr_high   = wr_i && (ptr_i == ALM_PTR_HIGH);
   assign wfield    = wdata_i[ALM_FLD_MSB:ALM_FLD_LSB];

   assign below_under = conv_code_i < under_r;
   assign above_over  = conv_code_i > over_r;
   // hysteresis margins, nine bits so no wrap
   assign under_plus  = {1'b0, under_r} + {1'b0, hyst_r};
   assign over_minus  = {1'b0, over_r} - {1'b0, hyst_r};
   assign under_rel   = {1'b0, conv_code_i} > under_plus;
   assign over_rel    = !over_minus[8] && ({1'b0, conv_code_i} < over_minus);

   assign lower_seen  = lowest_fresh_r || (conv_code_i < lowest_r);
   assign higher_seen = high_fresh_r || (conv_code_i > high_r);

   // restart codes; reserved bits arrive as zero, so match the field
   assign lowest_restart = wr_lowest && (wfield == ALM_LOWEST_CLR[ALM_FLD_MSB:ALM_FLD_LSB]);
   assign high_restart   = wr_high && (wfield == ALM_HIGH_CLR[ALM_FLD_MSB:ALM_FLD_LSB]);

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         under_r <= ALM_RST_UNDER;
         over_r  <= ALM_RST_OVER;
         hyst_r  <= ALM_RST_HYST;
      end else if (ce_i) begin
         if (wr_under) under_r <= wfield;
         if (wr_over)  over_r  <= wfield;
         if (wr_hyst)  hyst_r  <= wfield;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         lowest_r       <= ALM_RST_LOWEST;
         lowest_fresh_r <= 1'b0;
      end else if (ce_i) begin
         if (wr_lowest) begin
            lowest_r       <= wfield;
            lowest_fresh_r <= lowest_restart;
         end else if (track && lower_seen) begin
            lowest_r       <= conv_code_i;
            lowest_fresh_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         high_r       <= ALM_RST_HIGH;
         high_fresh_r <= 1'b0;
      end else if (ce_i) begin
         if (wr_high) begin
            high_r       <= wfield;
            high_fresh_r <= high_restart;
         end else if (track && higher_seen) begin
            high_r       <= conv_code_i;
            high_fresh_r <= 1'b0;
         end
      end
   end

   alm_alert_flag u_under (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .ce_i       (ce_i),
      .sample_i   (ce_i && conv_valid_i),
      .raise_i    (below_under),
      .release_i  (under_rel),
      .hold_i     (alert_hold_i),
      .sw_clear_i (clr_under_i),
      .flag_o     (under_flag_o)
   );

   alm_alert_flag u_over (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .ce_i       (ce_i),
      .sample_i   (ce_i && conv_valid_i),
      .raise_i    (above_over),
      .release_i  (over_rel),
      .hold_i     (alert_hold_i),
      .sw_clear_i (clr_over_i),
      .flag_o     (over_flag_o)
   );

   always_comb begin
      rd_sel = ALM_ZERO_WORD;
      case (ptr_i)
         ALM_PTR_UNDER:  rd_sel[ALM_FLD_MSB:ALM_FLD_LSB] = under_r;
         ALM_PTR_OVER:   rd_sel[ALM_FLD_MSB:ALM_FLD_LSB] = over_r;
         ALM_PTR_HYST:   rd_sel[ALM_FLD_MSB:ALM_FLD_LSB] = hyst_r;
         ALM_PTR_LOWEST: rd_sel[ALM_FLD_MSB:ALM_FLD_LSB] = lowest_r;
         ALM_PTR_HIGH:   rd_sel[ALM_FLD_MSB:ALM_FLD_LSB] = high_r;
         default:        rd_sel = ALM_ZERO_WORD;
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         rdata_r <= ALM_ZERO_WORD;
         rhit_r  <= 1'b0;
      end else if (ce_i) begin
         rdata_r <= rd_sel;
         rhit_r  <= (ptr_i >= ALM_PTR_UNDER) && (ptr_i <= ALM_PTR_HIGH);
      end
   end

   assign rdata_o = rdata_r;
   assign rhit_o  = rhit_r;

   property p_rsvd_zero;
      @(posedge core_clk_i) disable iff (rst_i)
         (rdata_o[15:12] == 4'h0) && (rdata_o[3:0] == 4'h0);
   endproperty
   a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved bits nonzero");

   property p_min_mono;
      @(posedge core_clk_i) disable iff (rst_i)
         (ce_i && !wr_lowest && !lowest_fresh_r) |=> (lowest_r <= $past(lowest_r));
   endproperty
   a_min_mono: assert property (p_min_mono) else $error("lowest rose without write");

   property p_max_mono;
      @(posedge core_clk_i) disable iff (rst_i)
         (ce_i && !wr_high && !high_fresh_r) |=> (high_r >= $past(high_r));
   endproperty
   a_max_mono: assert property (p_max_mono) else $error("highest fell without write");

   property p_no_track_normal;
      @(posedge core_clk_i) disable iff (rst_i)
         (!auto_mode && !wr_lowest && !wr_high) |=> $stable(lowest_r) && $stable(high_r);
   endproperty
   a_no_track_normal: assert property (p_no_track_normal) else $error("tracked in normal");

   sequence s_min_clr_wr;
      ce_i && lowest_restart;
   endsequence

   sequence s_min_next_conv;
      ce_i && track && !wr_lowest;
   endsequence

   property p_min_restart;
      @(posedge core_clk_i) disable iff (rst_i)
         s_min_clr_wr ##1 s_min_next_conv |=> (lowest_r == $past(conv_code_i));
   endproperty
   a_min_restart: assert property (p_min_restart) else $error("min not restarted");

   sequence s_max_clr_wr;
      ce_i && high_restart;
   endsequence

   sequence s_max_next_conv;
      ce_i && track && !wr_high;
   endsequence

   property p_max_restart;
      @(posedge core_clk_i) disable iff (rst_i)
         s_max_clr_wr ##1 s_max_next_conv |=> (high_r == $past(conv_code_i));
   endproperty
   a_max_restart: assert property (p_max_restart) else $error("max not restarted");

   property p_over_hyst;
      @(posedge core_clk_i) disable iff (rst_i)
         (over_flag_o && ce_i && conv_valid_i && !above_over && !over_rel && !clr_over_i)
         |=> over_flag_o;
   endproperty
   a_over_hyst: assert property (p_over_hyst) else $error("over flag cleared in band");

   property p_under_rel;
      @(posedge core_clk_i) disable iff (rst_i)
         (ce_i && conv_valid_i && under_rel && !below_under && !alert_hold_i)
         |=> !under_flag_o;
   endproperty
   a_under_rel: assert property (p_under_rel) else $error("under flag not self-cleared");

   property p_over_raise;
      @(posedge core_clk_i) disable iff (rst_i)
         (ce_i && conv_valid_i && above_over) |=> over_flag_o;
   endproperty
   a_over_raise: assert property (p_over_raise) else $error("over alert missed");
endmodule : alm_regs
`default_nettype wire

/* core/alm_pkg.sv */
// Function
// - Keep 8-bit under-range limit in bits 11:4; alert when result below it.
// - Keep 8-bit over-range limit in bits 11:4; alert when result above it.
// - Bits 15:12 and 3:0 read zero; master writes zeros there.
// - Raised alert self-clears only once result is inside limit by more than hysteresis.
// - With alert hold set, alerts never self-clear.
// - Lowest register replaced only by a strictly lower result.
// - Writing 0FFFh to lowest register restarts minimum tracking.
// - Highest register replaced only by a strictly higher result.
// - Writing 0000h to highest register restarts maximum tracking.
// - Tracking registers update only in automatic conversion mode.
// - Registers sit at consecutive pointers 03h to 07h, readable and writable.
// - Automatic mode runs whenever the cycle time field is non-zero.
// - Over flag clears below limit minus hyst; under flag above limit plus hyst.
package alm_pkg;
   typedef logic [7:0]  alm_ptr_t;
   typedef logic [15:0] alm_word_t;
   typedef logic [7:0]  alm_code_t;

   localparam alm_ptr_t  ALM_PTR_UNDER  = 8'h03;
   localparam alm_ptr_t  ALM_PTR_OVER   = 8'h04;
   localparam alm_ptr_t  ALM_PTR_HYST   = 8'h05;
   localparam alm_ptr_t  ALM_PTR_LOWEST = 8'h06;
   localparam alm_ptr_t  ALM_PTR_HIGH   = 8'h07;

   localparam int        ALM_FLD_LSB    = 4;
   localparam int        ALM_FLD_MSB    = 11;

   localparam alm_code_t ALM_RST_UNDER  = 8'h00;
   localparam alm_code_t ALM_RST_OVER   = 8'hff;
   localparam alm_code_t ALM_RST_HYST   = 8'h00;
   localparam alm_code_t ALM_RST_LOWEST = 8'hff;
   localparam alm_code_t ALM_RST_HIGH   = 8'h00;

   localparam alm_word_t ALM_LOWEST_CLR = 16'h0fff;
   localparam alm_word_t ALM_HIGH_CLR   = 16'h0000;
   localparam alm_word_t ALM_ZERO_WORD  = 16'h0000;
   localparam logic [2:0] ALM_CYC_OFF   = 3'h0;
endpackage : alm_pkg

/* core/alm_alert_flag.sv */
`timescale 1ns/1ps
`default_nettype none
module alm_alert_flag (
   input  wire logic core_clk_i,
   input  wire logic rst_i,
   input  wire logic ce_i,
   input  wire logic sample_i,
   input  wire logic raise_i,
   input  wire logic release_i,
   input  wire logic hold_i,
   input  wire logic sw_clear_i,
   output logic      flag_o
);
   logic flag_r;
   logic flag_nxt;

   // Set wins over software clear; self-clear only without hold
   assign flag_nxt = (sample_i && raise_i) ? 1'b1 :
                     sw_clear_i ? 1'b0 :
                     (sample_i && release_i && !hold_i) ? 1'b0 : flag_r;

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         flag_r <= 1'b0;
      end else if (ce_i) begin
         flag_r <= flag_nxt;
      end
   end

   assign flag_o = flag_r;

   property p_hold_keeps;
      @(posedge core_clk_i) disable iff (rst_i)
         (flag_r && hold_i && ce_i && !sw_clear_i) |=> flag_r;
   endproperty
   a_hold_keeps: assert property (p_hold_keeps) else $error("flag cleared under hold");

   property p_raise_sets;
      @(posedge core_clk_i) disable iff (rst_i)
         (ce_i && sample_i && raise_i) |=> flag_r;
   endproperty
   a_raise_sets: assert property (p_raise_sets) else $error("flag not set on raise");
endmodule : alm_alert_flag
`default_nettype wire

/* verif/alm_master_model.sv */
`timescale 1ns/1ps
`default_nettype none
module alm_master_model (
   input  wire logic               core_clk_i,
   input  wire alm_pkg::alm_word_t rdata_i,
   input  wire logic               rhit_i,
   output alm_pkg::alm_ptr_t       ptr_o,
   output logic                    wr_o,
   output alm_pkg::alm_word_t      wdata_o
);
   import alm_pkg::*;
   initial begin
      ptr_o   = 8'h00;
      wr_o    = 1'b0;
      wdata_o = 16'h0000;
   end
   task automatic write_reg(input alm_ptr_t p, input alm_word_t d);
      @(negedge core_clk_i);
      ptr_o   = p;
      wr_o    = 1'b1;
      wdata_o = d & 16'h0ff0;
      @(negedge core_clk_i);
      wr_o    = 1'b0;
      wdata_o = ~wdata_o;
   endtask : write_reg
   task automatic read_reg(input alm_ptr_t p, output alm_word_t d, output logic h);
      @(negedge core_clk_i);
      ptr_o = p;
      @(negedge core_clk_i);
      d = rdata_i;
      h = rhit_i;
   endtask : read_reg
endmodule : alm_master_model
`default_nettype wire

/* verif/test_alm_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module test_alm_regs;
   import alm_pkg::*;
   logic      core_clk_i = 1'b0;
   logic      rst_i, ce_i, wr_i, rhit_o, conv_valid_i, alert_hold_i;
   logic      clr_over_i, clr_under_i, over_flag_o, under_flag_o;
   alm_ptr_t  ptr_i;
   alm_word_t wdata_i, rdata_o;
   alm_code_t conv_code_i;
   logic [2:0] cycle_time_i;
   int        n_mismatch = 0;
   int        tests_run  = 0;
   alm_word_t rst_tab [5] = '{16'h0000, 16'h0ff0, 16'h0000, 16'h0ff0, 16'h0000};

   always #2.5 core_clk_i = ~core_clk_i;

   alm_regs uut (.core_clk_i(core_clk_i), .rst_i(rst_i), .ce_i(ce_i), .ptr_i(ptr_i),
      .wr_i(wr_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .rhit_o(rhit_o),
      .conv_valid_i(conv_valid_i), .conv_code_i(conv_code_i), .cycle_time_i(cycle_time_i),
      .alert_hold_i(alert_hold_i), .clr_over_i(clr_over_i), .clr_under_i(clr_under_i),
      .over_flag_o(over_flag_o), .under_flag_o(under_flag_o));
   alm_master_model mst (.core_clk_i(core_clk_i), .rdata_i(rdata_o), .rhit_i(rhit_o),
      .ptr_o(ptr_i), .wr_o(wr_i), .wdata_o(wdata_i));

   task automatic give_verdict;
      if (n_mismatch == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : give_verdict
   task automatic chk_word(input string n, input alm_word_t e, input alm_word_t g);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask : chk_word
   task automatic chk_bit(input string n, input logic e, input logic g);
      tests_run++;
      if (g !== e) begin
         n_mismatch++;
         $display("wrong value %s expected %b seen %b", n, e, g);
      end
   endtask : chk_bit
   task automatic rd_chk(input alm_ptr_t p, input alm_word_t e, input logic eh);
      alm_word_t d;
      logic      h;
      mst.read_reg(p, d, h);
      chk_word("rdata", e, d);
      chk_bit("rhit", eh, h);
   endtask : rd_chk
   // One conversion pulse, then the flags one cycle later
   task automatic cf(input alm_code_t c, input logic eo, input logic eu);
      @(negedge core_clk_i);
      conv_valid_i = 1'b1;
      conv_code_i  = c;
      @(negedge core_clk_i);
      conv_valid_i = 1'b0;
      conv_code_i  = ~c;
      chk_bit("over_flag", eo, over_flag_o);
      chk_bit("under_flag", eu, under_flag_o);
   endtask : cf

   initial begin
      #20000;
      n_mismatch++;
      give_verdict();
   end

   initial begin
      {rst_i, ce_i} = 2'b11;
      {conv_valid_i, alert_hold_i, clr_over_i, clr_under_i} = 4'h0;
      conv_code_i  = 8'h00;
      cycle_time_i = 3'h0;
      repeat (12) @(negedge core_clk_i);
      rst_i = 1'b0;
      for (int i = 0; i < 5; i++) rd_chk(alm_ptr_t'(ALM_PTR_UNDER + i), rst_tab[i], 1'b1);
      mst.write_reg(8'h09, 16'h0ab0);
      rd_chk(8'h09, 16'h0000, 1'b0);
      mst.write_reg(ALM_PTR_UNDER, 16'h0200);
      mst.write_reg(ALM_PTR_OVER, 16'h0c00);
      mst.write_reg(ALM_PTR_HYST, 16'h0100);
      rd_chk(ALM_PTR_UNDER, 16'h0200, 1'b1);
      rd_chk(ALM_PTR_OVER, 16'h0c00, 1'b1);
      rd_chk(ALM_PTR_HYST, 16'h0100, 1'b1);
      cf(8'h40, 1'b0, 1'b0);
      rd_chk(ALM_PTR_LOWEST, 16'h0ff0, 1'b1);
      rd_chk(ALM_PTR_HIGH, 16'h0000, 1'b1);
      cycle_time_i = 3'h1;
      cf(8'h80, 1'b0, 1'b0);
      cf(8'h90, 1'b0, 1'b0);
      rd_chk(ALM_PTR_LOWEST, 16'h0800, 1'b1);
      rd_chk(ALM_PTR_HIGH, 16'h0900, 1'b1);
      cf(8'h70, 1'b0, 1'b0);
      rd_chk(ALM_PTR_LOWEST, 16'h0700, 1'b1);
      // Conversion lands on the edge right after the restart write
      fork
         mst.write_reg(ALM_PTR_HIGH, ALM_HIGH_CLR);
         begin
            @(negedge core_clk_i);
            cf(8'h50, 1'b0, 1'b0);
         end
      join
      rd_chk(ALM_PTR_HIGH, 16'h0500, 1'b1);
      fork
         mst.write_reg(ALM_PTR_LOWEST, ALM_LOWEST_CLR);
         begin
            @(negedge core_clk_i);
            cf(8'h60, 1'b0, 1'b0);
         end
      join
      rd_chk(ALM_PTR_LOWEST, 16'h0600, 1'b1);
      cf(8'h1f, 1'b0, 1'b1);
      cf(8'h30, 1'b0, 1'b1);
      cf(8'h31, 1'b0, 1'b0);
      cf(8'hc1, 1'b1, 1'b0);
      cf(8'hb0, 1'b1, 1'b0);
      cf(8'haf, 1'b0, 1'b0);
      alert_hold_i = 1'b1;
      cf(8'hc1, 1'b1, 1'b0);
      cf(8'h80, 1'b1, 1'b0);
      clr_over_i = 1'b1;
      @(negedge core_clk_i);
      clr_over_i = 1'b0;
      chk_bit("over_flag", 1'b0, over_flag_o);
      cf(8'h10, 1'b0, 1'b1);
      cf(8'h60, 1'b0, 1'b1);
      clr_under_i = 1'b1;
      @(negedge core_clk_i);
      clr_under_i = 1'b0;
      chk_bit("under_flag", 1'b0, under_flag_o);
      cycle_time_i = 3'h7;
      cf(8'hf0, 1'b1, 1'b0);
      rd_chk(ALM_PTR_HIGH, 16'h0f00, 1'b1);
      // Clock enable low freezes registers and flags
      ce_i = 1'b0;
      mst.write_reg(ALM_PTR_UNDER, 16'h0300);
      cf(8'h00, 1'b1, 1'b0);
      ce_i = 1'b1;
      rd_chk(ALM_PTR_UNDER, 16'h0200, 1'b1);
      // Mid-run reset returns flags and tracking to defaults
      rst_i = 1'b1;
      @(negedge core_clk_i);
      rst_i = 1'b0;
      chk_bit("over_flag", 1'b0, over_flag_o);
      rd_chk(ALM_PTR_HIGH, 16'h0000, 1'b1);
      give_verdict();
   end
endmodule : test_alm_regs
`default_nettype wire
